/* File: clk_ctrl_pkg.sv */
package clk_ctrl_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MUL_W  = 12;

  // Register offsets
  localparam logic [2:0] OFF_LOOP_CONTROL      = 3'h0;
  localparam logic [2:0] OFF_BANDWIDTH_CONTROL = 3'h1;
  localparam logic [2:0] OFF_MULTIPLIER_HIGH   = 3'h2;
  localparam logic [2:0] OFF_MULTIPLIER_LOW    = 3'h3;
  localparam logic [2:0] OFF_VCO_RANGE_SELECT  = 3'h4;

  // loop_control field positions
  localparam int unsigned BIT_IE    = 7;
  localparam int unsigned BIT_FLAG  = 6;
  localparam int unsigned BIT_ON    = 5;
  localparam int unsigned BIT_BCS   = 4;
  localparam int unsigned BIT_RNG1  = 1;
  localparam int unsigned BIT_RNG0  = 0;

  // bandwidth_control field positions
  localparam int unsigned BIT_AUTO  = 7;
  localparam int unsigned BIT_LOCK  = 6;
  localparam int unsigned BIT_ACQ   = 5;

  // Reset values
  localparam logic       RST_IE        = 1'b0;
  localparam logic       RST_FLAG      = 1'b0;
  localparam logic       RST_ON        = 1'b1;
  localparam logic       RST_BCS       = 1'b0;
  localparam logic [1:0] RST_RANGE     = 2'h0;
  localparam logic       RST_AUTO      = 1'b0;
  localparam logic       RST_ACQ       = 1'b0;
  localparam logic [3:0] RST_MUL_HIGH  = 4'h0;
  localparam logic [7:0] RST_MUL_LOW   = 8'h40;
  localparam logic [7:0] RST_VCO_RANGE = 8'h40;

  // Edges of each clock waited for during a source switch
  localparam logic [1:0] SWITCH_EDGES  = 2'h3;

  // Number of synchronised inputs and their positions
  localparam int unsigned SYNC_N       = 4;
  localparam int unsigned SYN_LOCK     = 0;
  localparam int unsigned SYN_ACQ      = 1;
  localparam int unsigned SYN_XTAL     = 2;
  localparam int unsigned SYN_VCO      = 3;

endpackage : clk_ctrl_pkg

/* File: clk_sel_if.sv */
`timescale 1ns/1ps
interface clk_sel_if;
  logic select;
  logic vco_running;
  logic crystal_s;
  logic vco_s;
  logic base_out;
  logic switching;

  modport ctrl (
    output select,
    output vco_running,
    output crystal_s,
    output vco_s,
    input  base_out,
    input  switching
  );

  modport sw (
    input  select,
    input  vco_running,
    input  crystal_s,
    input  vco_s,
    output base_out,
    output switching
  );
endinterface : clk_sel_if

/* File: sync2.sv */
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Refuse an empty synchroniser at elaboration
  if (WIDTH < 1) begin : g_width_chk
    $error("sync2: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Stage one feeds only stage two
  always_comb begin
    s_nxt        = s_r;
    s_nxt.stage1 = async_in;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stage2;

endmodule : sync2

/* File: base_clock_switch.sv */
`timescale 1ns/1ps
module base_clock_switch (
  input  wire logic clk,
  input  wire logic rst_n,
  clk_sel_if.sw     sel
);

  typedef enum logic [0:0] {
    SW_RUN,
    SW_WAIT
  } sw_mode_t;

  typedef struct packed {
    sw_mode_t   mode;
    logic       active;
    logic       xtal_d;
    logic       vco_d;
    logic [1:0] xtal_cnt;
    logic [1:0] vco_cnt;
    logic       out;
  } sw_state_t;

  sw_state_t s_r;
  sw_state_t s_nxt;

  logic xtal_rise;
  logic vco_rise;
  logic src_rise;
  logic edges_done;

  assign xtal_rise  = sel.crystal_s & ~s_r.xtal_d;
  assign vco_rise   = sel.vco_s & ~s_r.vco_d;
  assign src_rise   = s_r.active ? vco_rise : xtal_rise;
  // A stopped VCO cannot deliver edges, so it is not waited for
  assign edges_done = (s_r.xtal_cnt == clk_ctrl_pkg::SWITCH_EDGES) &&
                      ((s_r.vco_cnt == clk_ctrl_pkg::SWITCH_EDGES) || !sel.vco_running);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.xtal_d = sel.crystal_s;
    s_nxt.vco_d  = sel.vco_s;
    case (s_r.mode)
      SW_RUN: begin
        if (sel.select != s_r.active) begin
          s_nxt.mode     = SW_WAIT;
          s_nxt.xtal_cnt = 2'h0;
          s_nxt.vco_cnt  = 2'h0;
        end else if (src_rise) begin
          s_nxt.out = ~s_r.out;
        end
      end
      SW_WAIT: begin
        // Output frozen while both clocks are counted out
        if (xtal_rise && s_r.xtal_cnt != clk_ctrl_pkg::SWITCH_EDGES) begin
          s_nxt.xtal_cnt = s_r.xtal_cnt + 2'h1;
        end
        if (vco_rise && s_r.vco_cnt != clk_ctrl_pkg::SWITCH_EDGES) begin
          s_nxt.vco_cnt = s_r.vco_cnt + 2'h1;
        end
        if (edges_done) begin
          s_nxt.mode   = SW_RUN;
          s_nxt.active = sel.select;
        end
      end
      default: begin
        s_nxt.mode = SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{mode: SW_RUN, active: clk_ctrl_pkg::RST_BCS, xtal_d: 1'b0, vco_d: 1'b0,
               xtal_cnt: 2'h0, vco_cnt: 2'h0, out: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sel.base_out  = s_r.out;
  assign sel.switching = (s_r.mode == SW_WAIT);

endmodule : base_clock_switch

/* File: clock_control_regs.sv */
`timescale 1ns/1ps
module clock_control_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        lock_detect,
  input  wire logic        tracking_detect,
  input  wire logic        crystal_clock,
  input  wire logic        vco_clock,
  output logic             loop_enable,
  output logic             tracking_mode,
  output logic      [1:0]  range_exponent,
  output logic      [7:0]  vco_range_value,
  output logic      [11:0] feedback_multiplier,
  output logic             irq,
  output logic             base_clock_output,
  output logic             base_clock_switching
);

  typedef struct packed {
    logic       ie;
    logic       flag;
    logic       on;
    logic       base_clock_select;
    logic [1:0] range;
    logic       autobw;
    logic       acq_manual;
    logic       lock_prev;
    logic [3:0] mul_high;
    logic [7:0] mul_low;
    logic [7:0] vco_range;
    logic [7:0] rdata;
  } reg_state_t;

  reg_state_t s_r;
  reg_state_t s_nxt;

  logic [clk_ctrl_pkg::SYNC_N-1:0] raw_in;
  logic [clk_ctrl_pkg::SYNC_N-1:0] syn_in;

  clk_sel_if sel_bus ();

  // Analog and clock inputs all cross into the bus clock domain
  assign raw_in[clk_ctrl_pkg::SYN_LOCK] = lock_detect;
  assign raw_in[clk_ctrl_pkg::SYN_ACQ]  = tracking_detect;
  assign raw_in[clk_ctrl_pkg::SYN_XTAL] = crystal_clock;
  assign raw_in[clk_ctrl_pkg::SYN_VCO]  = vco_clock;

  sync2 #(
    .WIDTH (clk_ctrl_pkg::SYNC_N)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  base_clock_switch u_switch (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (sel_bus.sw)
  );

  function automatic logic [11:0] effective_mul(input logic [3:0] hi, input logic [7:0] lo);
    logic [11:0] m;
    m = {hi, lo};
    effective_mul = (m == 12'h000) ? 12'h001 : m;
  endfunction : effective_mul

  function automatic logic addr_hit(input logic [2:0] a, input logic [2:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  logic lock_sync;
  logic acq_sync;
  logic lock_ind;
  logic acq_view;
  logic lock_toggle;
  logic wr_loop;
  logic wr_bw;
  logic wr_mh;
  logic wr_ml;
  logic wr_vr;
  logic rd_loop;
  logic on_next;
  logic range_ok_next;
  logic [7:0] loop_view;
  logic [7:0] bw_view;
  logic [7:0] rd_mux;

  assign lock_sync = syn_in[clk_ctrl_pkg::SYN_LOCK];
  assign acq_sync  = syn_in[clk_ctrl_pkg::SYN_ACQ];

  // Lock indicator follows the detector only in automatic mode
  assign lock_ind    = s_r.autobw & lock_sync;
  assign lock_toggle = lock_ind != s_r.lock_prev;
  assign acq_view    = s_r.autobw ? acq_sync : s_r.acq_manual;

  assign wr_loop = wr && addr_hit(addr, clk_ctrl_pkg::OFF_LOOP_CONTROL);
  assign wr_bw   = wr && addr_hit(addr, clk_ctrl_pkg::OFF_BANDWIDTH_CONTROL);
  assign wr_mh   = wr && addr_hit(addr, clk_ctrl_pkg::OFF_MULTIPLIER_HIGH);
  assign wr_ml   = wr && addr_hit(addr, clk_ctrl_pkg::OFF_MULTIPLIER_LOW);
  assign wr_vr   = wr && addr_hit(addr, clk_ctrl_pkg::OFF_VCO_RANGE_SELECT);
  assign rd_loop = rd && addr_hit(addr, clk_ctrl_pkg::OFF_LOOP_CONTROL);

  always_comb begin
    loop_view = 8'h00;
    loop_view[clk_ctrl_pkg::BIT_IE]   = s_r.ie & s_r.autobw;
    loop_view[clk_ctrl_pkg::BIT_FLAG] = s_r.flag & s_r.autobw;
    loop_view[clk_ctrl_pkg::BIT_ON]   = s_r.on;
    loop_view[clk_ctrl_pkg::BIT_BCS]  = s_r.base_clock_select;
    loop_view[clk_ctrl_pkg::BIT_RNG1] = s_r.range[1];
    loop_view[clk_ctrl_pkg::BIT_RNG0] = s_r.range[0];
  end

  always_comb begin
    bw_view = 8'h00;
    bw_view[clk_ctrl_pkg::BIT_AUTO] = s_r.autobw;
    bw_view[clk_ctrl_pkg::BIT_LOCK] = lock_ind;
    bw_view[clk_ctrl_pkg::BIT_ACQ]  = acq_view;
  end

  always_comb begin
    case (addr)
      clk_ctrl_pkg::OFF_LOOP_CONTROL:      rd_mux = loop_view;
      clk_ctrl_pkg::OFF_BANDWIDTH_CONTROL: rd_mux = bw_view;
      clk_ctrl_pkg::OFF_MULTIPLIER_HIGH:   rd_mux = {4'h0, s_r.mul_high};
      clk_ctrl_pkg::OFF_MULTIPLIER_LOW:    rd_mux = s_r.mul_low;
      clk_ctrl_pkg::OFF_VCO_RANGE_SELECT:  rd_mux = s_r.vco_range;
      default:                             rd_mux = 8'h00;
    endcase
  end

  // Loop on value after this cycle's write, and the range check it meets
  assign on_next = wr_loop ? (wdata[clk_ctrl_pkg::BIT_ON] | s_r.base_clock_select) : s_r.on;
  assign range_ok_next = wr_vr && !s_r.on ? (wdata != 8'h00) : (s_r.vco_range != 8'h00);

  always_comb begin
    s_nxt           = s_r;
    s_nxt.lock_prev = lock_ind;
    s_nxt.rdata     = rd ? rd_mux : 8'h00;

    // Read clears the flag, but a toggle in the same cycle wins
    if (rd_loop) begin
      s_nxt.flag = 1'b0;
    end
    if (lock_toggle) begin
      s_nxt.flag = 1'b1;
    end

    if (wr_loop) begin
      if (s_r.autobw) begin
        s_nxt.ie = wdata[clk_ctrl_pkg::BIT_IE];
      end
      s_nxt.on = on_next;
      // Select can be set only if the loop was already on
      s_nxt.base_clock_select = wdata[clk_ctrl_pkg::BIT_BCS] & (s_r.on | s_r.base_clock_select);
      if (!s_r.on) begin
        s_nxt.range = {wdata[clk_ctrl_pkg::BIT_RNG1], wdata[clk_ctrl_pkg::BIT_RNG0]};
      end
    end

    // Forced clear of the select bit
    if (!on_next || !range_ok_next) begin
      s_nxt.base_clock_select = 1'b0;
    end

    if (wr_bw) begin
      s_nxt.autobw = wdata[clk_ctrl_pkg::BIT_AUTO];
      if (!s_r.autobw) begin
        s_nxt.acq_manual = wdata[clk_ctrl_pkg::BIT_ACQ];
      end
    end

    if (!s_r.on) begin
      if (wr_mh) begin
        s_nxt.mul_high = wdata[3:0];
      end
      if (wr_ml) begin
        s_nxt.mul_low = wdata;
      end
      if (wr_vr) begin
        s_nxt.vco_range = wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{ie:         clk_ctrl_pkg::RST_IE,
               flag:       clk_ctrl_pkg::RST_FLAG,
               on:         clk_ctrl_pkg::RST_ON,
               base_clock_select:        clk_ctrl_pkg::RST_BCS,
               range:      clk_ctrl_pkg::RST_RANGE,
               autobw:     clk_ctrl_pkg::RST_AUTO,
               acq_manual: clk_ctrl_pkg::RST_ACQ,
               lock_prev:  1'b0,
               mul_high:   clk_ctrl_pkg::RST_MUL_HIGH,
               mul_low:    clk_ctrl_pkg::RST_MUL_LOW,
               vco_range:  clk_ctrl_pkg::RST_VCO_RANGE,
               rdata:      8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sel_bus.select      = s_r.base_clock_select;
  assign sel_bus.vco_running = loop_enable;
  assign sel_bus.crystal_s   = syn_in[clk_ctrl_pkg::SYN_XTAL];
  assign sel_bus.vco_s       = syn_in[clk_ctrl_pkg::SYN_VCO];

  assign rdata                = s_r.rdata;
  assign loop_enable          = s_r.on && (s_r.vco_range != 8'h00);
  assign tracking_mode        = acq_view;
  assign range_exponent       = s_r.range;
  assign vco_range_value      = s_r.vco_range;
  assign feedback_multiplier  = effective_mul(s_r.mul_high, s_r.mul_low);
  assign irq                  = s_r.flag & s_r.ie & s_r.autobw;
  assign base_clock_output    = sel_bus.base_out;
  assign base_clock_switching = sel_bus.switching;

endmodule : clock_control_regs

/* File: clock_control_regs_sva.sv */
`timescale 1ns/1ps
module clk_ctrl_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        loop_enable,
  input wire logic [1:0]  range_exponent,
  input wire logic [7:0]  vco_range_value,
  input wire logic [11:0] feedback_multiplier,
  input wire logic        irq,
  input wire logic        base_clock_output,
  input wire logic        base_clock_switching
);
  logic auto_r;
  logic wr_lo;
  logic wr_mul;
  // Shadow of the bandwidth mode bit, which software writes freely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      auto_r <= 1'b0;
    else if (wr && addr == clk_ctrl_pkg::OFF_BANDWIDTH_CONTROL)
      auto_r <= wdata[clk_ctrl_pkg::BIT_AUTO];
  end
  assign wr_lo  = wr && addr == clk_ctrl_pkg::OFF_LOOP_CONTROL;
  assign wr_mul = wr && (addr == clk_ctrl_pkg::OFF_MULTIPLIER_HIGH || addr == clk_ctrl_pkg::OFF_MULTIPLIER_LOW);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ie_manual_a : assert property (
    $past(rd && addr == clk_ctrl_pkg::OFF_LOOP_CONTROL && !auto_r) |-> rdata[7:6] == 2'h0)
    else $error("enable or flag seen in manual mode");
  lock_manual_a : assert property (
    $past(rd && addr == clk_ctrl_pkg::OFF_BANDWIDTH_CONTROL && !auto_r) |-> !rdata[6])
    else $error("lock seen in manual mode");
  high_nibble_a : assert property (
    $past(rd && addr == clk_ctrl_pkg::OFF_MULTIPLIER_HIGH) |-> rdata[7:4] == 4'h0)
    else $error("multiplier high upper bits not zero");
  mul_nonzero_a : assert property (feedback_multiplier != 12'h000)
    else $error("multiplier zero not presented as one");
  range_lock_a : assert property (loop_enable && wr_lo |=> $stable(range_exponent))
    else $error("range changed while loop on");
  mul_lock_a : assert property (loop_enable && wr_mul |=> $stable(feedback_multiplier))
    else $error("multiplier changed while loop on");
  vco_lock_a : assert property (
    loop_enable && wr && addr == clk_ctrl_pkg::OFF_VCO_RANGE_SELECT |=> $stable(vco_range_value))
    else $error("vco range changed while loop on");
  vco_zero_a : assert property (vco_range_value == 8'h00 |-> !loop_enable)
    else $error("loop enabled with zero range");
  out_frozen_a : assert property (
    $past(base_clock_switching) && base_clock_switching |-> $stable(base_clock_output))
    else $error("base clock moved during switch");
  switch_end_a : assert property ($rose(base_clock_switching) |-> ##[1:200] !base_clock_switching)
    else $error("source switch did not end");
  irq_auto_a : assert property (irq |-> auto_r)
    else $error("interrupt in manual mode");
endmodule : clk_ctrl_sva

bind clock_control_regs clk_ctrl_sva u_sva (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .loop_enable(loop_enable), .range_exponent(range_exponent), .vco_range_value(vco_range_value),
  .feedback_multiplier(feedback_multiplier), .irq(irq), .base_clock_output(base_clock_output),
  .base_clock_switching(base_clock_switching));

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, wr, rd, lock_detect, tracking_detect, crystal_clock, vco_clock;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, vco_range_value, h, l;
  logic [1:0]  range_exponent;
  logic [11:0] feedback_multiplier;
  logic        loop_enable, tracking_mode, irq, base_clock_output, base_clock_switching;
  logic [31:0] seed;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          xc = 0;
  int          vc = 0;

  clock_control_regs dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lock_detect(lock_detect), .tracking_detect(tracking_detect), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .loop_enable(loop_enable), .tracking_mode(tracking_mode),
    .range_exponent(range_exponent), .vco_range_value(vco_range_value),
    .feedback_multiplier(feedback_multiplier), .irq(irq), .base_clock_output(base_clock_output),
    .base_clock_switching(base_clock_switching));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Crystal period 8 cycles, VCO period 6 cycles; both slower than clk/2
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xc <= (xc == 3) ? 0 : xc + 1;
    vc <= (vc == 2) ? 0 : vc + 1;
    if (xc == 3)
      crystal_clock <= !crystal_clock;
    if (vc == 2)
      vco_clock <= !vco_clock;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [11:0] fb_exp(input logic [7:0] hi, input logic [7:0] lo);
    return ({hi[3:0], lo} == 12'h000) ? 12'h001 : {hi[3:0], lo};
  endfunction : fb_exp

  task automatic summarize;
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: value %h, want %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_b(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: flag %b, want %b", $time, g, e);
    end
  endtask : chk_b

  task automatic wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_t

  task automatic rd_t(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({4'h0, rdata}, {4'h0, e});
  endtask : rd_t

  // Cycles between two toggles of the base clock output
  task automatic period_t(input int e);
    logic v;
    int   n;
    @(negedge clk);
    v = base_clock_output;
    while (base_clock_output === v) @(negedge clk);
    v = base_clock_output;
    n = 0;
    while (base_clock_output === v) begin
      @(negedge clk);
      n++;
    end
    chk(12'(n), 12'(e));
  endtask : period_t

  task automatic sw_t;
    int n;
    n = 0;
    while (base_clock_switching !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk_b(base_clock_switching, 1'b1);
    while (base_clock_switching !== 1'b0) @(negedge clk);
  endtask : sw_t

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    lock_detect = 1'b0;
    tracking_detect = 1'b0;
    crystal_clock = 1'b0;
    vco_clock = 1'b0;
    seed = 32'h0000_63e5;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_t(3'h0, 8'h20);
    rd_t(3'h1, 8'h00);
    rd_t(3'h2, 8'h00);
    rd_t(3'h3, 8'h40);
    rd_t(3'h4, 8'h40);
    rd_t(3'h5, 8'h00);
    chk(feedback_multiplier, 12'h040);
    period_t(8);
    // Writes refused while the loop runs
    wr_t(3'h2, 8'h0f);
    wr_t(3'h3, 8'h00);
    wr_t(3'h0, 8'h21);
    wr_t(3'h4, 8'h00);
    rd_t(3'h2, 8'h00);
    rd_t(3'h3, 8'h40);
    rd_t(3'h0, 8'h20);
    rd_t(3'h4, 8'h40);
    chk(12'(vco_range_value), 12'h040);
    wr_t(3'h0, 8'h30);
    sw_t();
    rd_t(3'h0, 8'h30);
    period_t(6);
    wr_t(3'h0, 8'h00);
    rd_t(3'h0, 8'h20);
    sw_t();
    period_t(8);
    wr_t(3'h0, 8'h00);
    wr_t(3'h0, 8'h10);
    rd_t(3'h0, 8'h00);
    chk_b(loop_enable, 1'b0);
    wr_t(3'h4, 8'h00);
    wr_t(3'h0, 8'h20);
    wr_t(3'h0, 8'h30);
    rd_t(3'h0, 8'h20);
    chk_b(loop_enable, 1'b0);
    wr_t(3'h0, 8'h00);
    wr_t(3'h4, 8'h40);
    wr_t(3'h1, 8'h00);
    wr_t(3'h3, 8'h20);
    wr_t(3'h0, 8'h20);
    wr_t(3'h0, 8'h30);
    rd_t(3'h0, 8'h30);
    sw_t();
    wr_t(3'h0, 8'h00);
    wr_t(3'h0, 8'h00);
    rd_t(3'h0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_t(3'h0, 8'(i));
      rd_t(3'h0, 8'(i));
      chk(12'(range_exponent), 12'(i));
    end
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      h = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[15:8];
      l = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      wr_t(3'h2, h);
      wr_t(3'h3, l);
      rd_t(3'h2, {4'h0, h[3:0]});
      rd_t(3'h3, l);
      chk(feedback_multiplier, fb_exp(h, l));
    end
    // Lock activity in manual mode stays hidden
    wr_t(3'h0, 8'h82);
    lock_detect <= 1'b1;
    repeat (6) @(posedge clk);
    rd_t(3'h0, 8'h02);
    rd_t(3'h1, 8'h00);
    wr_t(3'h1, 8'h20);
    rd_t(3'h1, 8'h20);
    chk_b(tracking_mode, 1'b1);
    // Manual acquisition value rewritten as 1 in the same write that enters automatic mode
    wr_t(3'h1, 8'ha0);
    repeat (4) @(posedge clk);
    rd_t(3'h1, 8'hc0);
    chk_b(tracking_mode, 1'b0);
    wr_t(3'h1, 8'h80);
    wr_t(3'h0, 8'h82);
    @(negedge clk);
    chk_b(irq, 1'b1);
    rd_t(3'h0, 8'hc2);
    chk_b(irq, 1'b0);
    rd_t(3'h0, 8'h82);
    @(posedge clk);
    lock_detect <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk_b(irq, 1'b1);
    wr_t(3'h1, 8'h00);
    rd_t(3'h1, 8'h20);
    rd_t(3'h0, 8'h02);
    chk_b(irq, 1'b0);
    summarize();
  end
endmodule : tb_top
